/* rmd_decoder.sv */
// rmd_decoder: register/memory class opcode decoder with registered outputs
// What this block does
// RULE_01: upper nibble A,B,C,F,E,D gives mode and length 2,2,3,1,2,3 bytes.
// RULE_02: nibble 9 adds operand and carry; 2,3,4,3,4,5 cycles by mode.
// RULE_03: nibble 2 subtracts operand and borrow into accumulator, six modes.
// RULE_04: nibble 8 puts accumulator xor operand into accumulator, all modes.
// RULE_05: nibble 1 compares accumulator with operand; flags only, 2-5 cycles.
// RULE_06: nibble 5 ands accumulator with operand for flags only.
// RULE_07: others: load, store, add, sub, and, or, index compare, jump, call.
// RULE_08: register operand is accumulator or index; jump and call take none.
// RULE_09: half carry set on carry from bit 3 into bit 4 for adds.
module rmd_decoder (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic opcode_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] idx_in,
  input wire logic [7:0] mem_in,
  input wire logic carry_in,
  output logic dec_valid_q,
  output logic dec_illegal_q,
  output rmd_pkg::rmd_op_t dec_op_q,
  output rmd_pkg::rmd_mode_t dec_mode_q,
  output rmd_pkg::rmd_reg_t dec_reg_q,
  output logic [1:0] dec_len_q,
  output logic [3:0] dec_cycles_q,
  output logic dec_mem_write_q,
  output logic dec_mem_read_q,
  output logic [7:0] result_q,
  output logic acc_we_q,
  output logic idx_we_q,
  output logic half_carry_q,
  output logic carry_q,
  output logic hc_we_q
);

  wire [3:0] hi = opcode[7:4];
  wire [3:0] lo = opcode[3:0];

  // mode, length and base cycles from upper nibble
  rmd_pkg::rmd_mode_t mode_w;
  logic [1:0] len_w;
  logic [3:0] base_w;
  always_comb begin
    mode_w = rmd_pkg::RMD_MODE_NONE;
    len_w = 2'h_0;
    base_w = 4'h_0;
    unique case (hi) // [RULE_01]
      rmd_pkg::HI_IMM: begin
        mode_w = rmd_pkg::RMD_MODE_IMM;
        len_w = rmd_pkg::LEN_IMM;
        base_w = rmd_pkg::CYC_IMM;
      end
      rmd_pkg::HI_DIR: begin
        mode_w = rmd_pkg::RMD_MODE_DIR;
        len_w = rmd_pkg::LEN_DIR;
        base_w = rmd_pkg::CYC_DIR;
      end
      rmd_pkg::HI_EXT: begin
        mode_w = rmd_pkg::RMD_MODE_EXT;
        len_w = rmd_pkg::LEN_EXT;
        base_w = rmd_pkg::CYC_EXT;
      end
      rmd_pkg::HI_IX2: begin
        mode_w = rmd_pkg::RMD_MODE_IX2;
        len_w = rmd_pkg::LEN_IX2;
        base_w = rmd_pkg::CYC_IX2;
      end
      rmd_pkg::HI_IX1: begin
        mode_w = rmd_pkg::RMD_MODE_IX1;
        len_w = rmd_pkg::LEN_IX1;
        base_w = rmd_pkg::CYC_IX1;
      end
      rmd_pkg::HI_IX0: begin
        mode_w = rmd_pkg::RMD_MODE_IX0;
        len_w = rmd_pkg::LEN_IX0;
        base_w = rmd_pkg::CYC_IX0;
      end
      default: mode_w = rmd_pkg::RMD_MODE_NONE;
    endcase
  end

  // operation and register operand from lower nibble
  rmd_pkg::rmd_op_t op_w;
  rmd_pkg::rmd_reg_t reg_w;
  always_comb begin
    op_w = rmd_pkg::RMD_OP_NONE;
    reg_w = rmd_pkg::RMD_REG_ACC; // [RULE_08]
    unique case (lo) // [RULE_07]
      rmd_pkg::LO_SUB: op_w = rmd_pkg::RMD_OP_SUB;
      rmd_pkg::LO_COMPARE_ACC: begin // [RULE_05]
        op_w = rmd_pkg::RMD_OP_COMPARE_ACC;
      end
      rmd_pkg::LO_MINUS_BORROW: begin // [RULE_03]
        op_w = rmd_pkg::RMD_OP_MINUS_BORROW;
      end
      rmd_pkg::LO_COMPARE_IDX: begin
        op_w = rmd_pkg::RMD_OP_COMPARE_IDX;
        reg_w = rmd_pkg::RMD_REG_IDX;
      end
      rmd_pkg::LO_AND: op_w = rmd_pkg::RMD_OP_AND;
      rmd_pkg::LO_BIT: op_w = rmd_pkg::RMD_OP_BIT_TEST; // [RULE_06]
      rmd_pkg::LO_LOAD_ACC: op_w = rmd_pkg::RMD_OP_LOAD_ACC;
      rmd_pkg::LO_STORE_ACC: op_w = rmd_pkg::RMD_OP_STORE_ACC;
      rmd_pkg::LO_XOR: op_w = rmd_pkg::RMD_OP_XOR; // [RULE_04]
      rmd_pkg::LO_ADC: op_w = rmd_pkg::RMD_OP_ADC; // [RULE_02]
      rmd_pkg::LO_OR: op_w = rmd_pkg::RMD_OP_OR;
      rmd_pkg::LO_ADD: op_w = rmd_pkg::RMD_OP_ADD;
      rmd_pkg::LO_JUMP: begin
        op_w = rmd_pkg::RMD_OP_JUMP;
        reg_w = rmd_pkg::RMD_REG_NONE; // [RULE_08]
      end
      rmd_pkg::LO_CALL: begin
        op_w = rmd_pkg::RMD_OP_CALL;
        reg_w = rmd_pkg::RMD_REG_NONE; // [RULE_08]
      end
      rmd_pkg::LO_LOAD_IDX: begin
        op_w = rmd_pkg::RMD_OP_LOAD_IDX;
        reg_w = rmd_pkg::RMD_REG_IDX;
      end
      rmd_pkg::LO_STORE_IDX: begin
        op_w = rmd_pkg::RMD_OP_STORE_IDX;
        reg_w = rmd_pkg::RMD_REG_IDX;
      end
    endcase
  end

  wire is_store = (lo == rmd_pkg::LO_STORE_ACC) |
                  (lo == rmd_pkg::LO_STORE_IDX);
  wire is_jump = (lo == rmd_pkg::LO_JUMP);
  wire is_call = (lo == rmd_pkg::LO_CALL);
  wire is_imm = (mode_w == rmd_pkg::RMD_MODE_IMM);
  // stores, jump and call have no immediate form
  wire no_imm_form = is_store | is_jump | is_call; // [RULE_07]
  wire legal = (mode_w != rmd_pkg::RMD_MODE_NONE) & ~(is_imm & no_imm_form);
  wire [3:0] cyc_w = is_store ? base_w + rmd_pkg::CYC_ADJ_STORE :
                     is_call ? base_w + rmd_pkg::CYC_ADJ_CALL :
                     is_jump ? base_w - rmd_pkg::CYC_ADJ_JUMP : base_w;
  // memory is only touched for data, not for jump targets
  wire rd_w = legal & ~is_store & ~is_jump & ~is_call & ~is_imm;
  wire wr_w = legal & is_store;
  wire take = opcode_valid & legal;
  rmd_pkg::rmd_op_t exec_op_w;
  assign exec_op_w = take ? op_w : rmd_pkg::RMD_OP_NONE;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_valid_q <= 1'b0;
      dec_illegal_q <= 1'b0;
      dec_op_q <= rmd_pkg::RMD_OP_NONE;
      dec_mode_q <= rmd_pkg::RMD_MODE_NONE;
      dec_reg_q <= rmd_pkg::RMD_REG_NONE;
      dec_len_q <= 2'h_0;
      dec_cycles_q <= 4'h_0;
      dec_mem_write_q <= 1'b0;
      dec_mem_read_q <= 1'b0;
    end else begin
      dec_valid_q <= take;
      dec_illegal_q <= opcode_valid & ~legal;
      dec_op_q <= exec_op_w;
      dec_mode_q <= take ? mode_w : rmd_pkg::RMD_MODE_NONE;
      dec_reg_q <= take ? reg_w : rmd_pkg::RMD_REG_NONE;
      dec_len_q <= take ? len_w : 2'h_0; // [RULE_01]
      dec_cycles_q <= take ? cyc_w : 4'h_0; // [RULE_02]
      dec_mem_write_q <= opcode_valid & wr_w;
      dec_mem_read_q <= opcode_valid & rd_w;
    end
  end

  rmd_alu u_alu (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .exec_valid(take),
    .exec_op(exec_op_w),
    .acc_in(acc_in),
    .idx_in(idx_in),
    .mem_in(mem_in),
    .carry_in(carry_in),
    .result_q(result_q),
    .acc_we_q(acc_we_q),
    .idx_we_q(idx_we_q),
    .half_carry_q(half_carry_q),
    .carry_q(carry_q),
    .hc_we_q(hc_we_q)
  );

  chk_mode_length: assert property ( // [RULE_01]
    @(posedge sys_clk) disable iff (!rst_n)
    (opcode_valid && opcode[7:4] == 4'h_F && opcode[3:0] == 4'h_6) |=>
      (dec_len_q == 2'h_1 && dec_mode_q == rmd_pkg::RMD_MODE_IX0))
    else $error("indexed no-offset length wrong");
  chk_adc_cycles: assert property ( // [RULE_02]
    @(posedge sys_clk) disable iff (!rst_n)
    (opcode_valid && opcode == 8'h_D9) |=> (dec_cycles_q == 4'h_5))
    else $error("sum with carry cycles wrong");
  chk_borrow_write: assert property ( // [RULE_03]
    @(posedge sys_clk) disable iff (!rst_n)
    (opcode_valid && opcode == 8'h_A2) |=>
      (acc_we_q && result_q == $past(acc_in) - $past(mem_in)
       - {7'h_00, $past(carry_in)}))
    else $error("subtract with borrow result wrong");
  chk_xor_result: assert property ( // [RULE_04]
    @(posedge sys_clk) disable iff (!rst_n)
    (opcode_valid && opcode == 8'h_E8) |=>
      (acc_we_q && result_q == ($past(acc_in) ^ $past(mem_in))))
    else $error("xor result wrong");
  chk_compare_noacc: assert property ( // [RULE_05]
    @(posedge sys_clk) disable iff (!rst_n)
    (opcode_valid && opcode == 8'h_A1) |=>
      (!acc_we_q && dec_cycles_q == 4'h_2))
    else $error("compare must not write accumulator");
  chk_bit_noacc: assert property ( // [RULE_06]
    @(posedge sys_clk) disable iff (!rst_n)
    (opcode_valid && opcode[3:0] == 4'h_5 && opcode[7:4] >= 4'h_A) |=>
      (!acc_we_q && !dec_mem_write_q))
    else $error("bit test must not modify state");
  chk_store_noimm: assert property ( // [RULE_07]
    @(posedge sys_clk) disable iff (!rst_n)
    (opcode_valid && opcode == 8'h_A7) |=> (dec_illegal_q && !dec_valid_q))
    else $error("store immediate must be refused");
  chk_jump_noreg: assert property ( // [RULE_08]
    @(posedge sys_clk) disable iff (!rst_n)
    (opcode_valid && opcode[3:0] == 4'h_C && opcode[7:4] >= 4'h_B) |=>
      (dec_reg_q == rmd_pkg::RMD_REG_NONE && dec_cycles_q != 4'h_0))
    else $error("jump must have no register operand");
  chk_half_carry: assert property ( // [RULE_09]
    @(posedge sys_clk) disable iff (!rst_n)
    (opcode_valid && opcode == 8'h_AB && acc_in == 8'h_08
     && mem_in == 8'h_08) |=> (hc_we_q && half_carry_q))
    else $error("half carry not set");

  cov_call: cover property (@(posedge sys_clk) disable iff (!rst_n)
    opcode_valid && opcode == 8'h_DD ##1 dec_cycles_q == 4'h_7);
  cov_adc: cover property (@(posedge sys_clk) disable iff (!rst_n)
    opcode_valid && opcode[3:0] == 4'h_9 ##1 carry_q);
  cov_illegal: cover property (@(posedge sys_clk) disable iff (!rst_n)
    dec_illegal_q);

endmodule // rmd_decoder

/* rmd_pkg.sv */
// rmd_pkg: shared constants and types for the register/memory opcode decoder
package rmd_pkg;

  // addressing mode codes (upper nibble of the opcode)
  localparam logic [3:0] HI_IMM = 4'h_A;
  localparam logic [3:0] HI_DIR = 4'h_B;
  localparam logic [3:0] HI_EXT = 4'h_C;
  localparam logic [3:0] HI_IX2 = 4'h_D;
  localparam logic [3:0] HI_IX1 = 4'h_E;
  localparam logic [3:0] HI_IX0 = 4'h_F;

  // operation codes (lower nibble of the opcode)
  localparam logic [3:0] LO_SUB = 4'h_0;
  localparam logic [3:0] LO_COMPARE_ACC = 4'h_1;
  localparam logic [3:0] LO_MINUS_BORROW = 4'h_2;
  localparam logic [3:0] LO_COMPARE_IDX = 4'h_3;
  localparam logic [3:0] LO_AND = 4'h_4;
  localparam logic [3:0] LO_BIT = 4'h_5;
  localparam logic [3:0] LO_LOAD_ACC = 4'h_6;
  localparam logic [3:0] LO_STORE_ACC = 4'h_7;
  localparam logic [3:0] LO_XOR = 4'h_8;
  localparam logic [3:0] LO_ADC = 4'h_9;
  localparam logic [3:0] LO_OR = 4'h_A;
  localparam logic [3:0] LO_ADD = 4'h_B;
  localparam logic [3:0] LO_JUMP = 4'h_C;
  localparam logic [3:0] LO_CALL = 4'h_D;
  localparam logic [3:0] LO_LOAD_IDX = 4'h_E;
  localparam logic [3:0] LO_STORE_IDX = 4'h_F;

  // instruction lengths in bytes, per mode
  localparam logic [1:0] LEN_IMM = 2'h_2;
  localparam logic [1:0] LEN_DIR = 2'h_2;
  localparam logic [1:0] LEN_EXT = 2'h_3;
  localparam logic [1:0] LEN_IX0 = 2'h_1;
  localparam logic [1:0] LEN_IX1 = 2'h_2;
  localparam logic [1:0] LEN_IX2 = 2'h_3;

  // base cycle counts of a read operation, per mode
  localparam logic [3:0] CYC_IMM = 4'h_2;
  localparam logic [3:0] CYC_DIR = 4'h_3;
  localparam logic [3:0] CYC_EXT = 4'h_4;
  localparam logic [3:0] CYC_IX0 = 4'h_3;
  localparam logic [3:0] CYC_IX1 = 4'h_4;
  localparam logic [3:0] CYC_IX2 = 4'h_5;
  // adjustments against the read-operation base
  localparam logic [3:0] CYC_ADJ_STORE = 4'h_1;
  localparam logic [3:0] CYC_ADJ_CALL = 4'h_2;
  localparam logic [3:0] CYC_ADJ_JUMP = 4'h_1;

  // half-carry is the carry out of this bit position
  localparam int HC_BIT = 3;

  typedef enum logic [2:0] {
    RMD_MODE_NONE,
    RMD_MODE_IMM,
    RMD_MODE_DIR,
    RMD_MODE_EXT,
    RMD_MODE_IX0,
    RMD_MODE_IX1,
    RMD_MODE_IX2
  } rmd_mode_t;

  // seventeen operations need five bits
  typedef enum logic [4:0] {
    RMD_OP_NONE,
    RMD_OP_LOAD_ACC,
    RMD_OP_LOAD_IDX,
    RMD_OP_STORE_ACC,
    RMD_OP_STORE_IDX,
    RMD_OP_ADD,
    RMD_OP_ADC,
    RMD_OP_SUB,
    RMD_OP_MINUS_BORROW,
    RMD_OP_AND,
    RMD_OP_OR,
    RMD_OP_XOR,
    RMD_OP_COMPARE_ACC,
    RMD_OP_COMPARE_IDX,
    RMD_OP_BIT_TEST,
    RMD_OP_JUMP,
    RMD_OP_CALL
  } rmd_op_t;

  // register operand selector
  typedef enum logic [1:0] {
    RMD_REG_NONE,
    RMD_REG_ACC,
    RMD_REG_IDX
  } rmd_reg_t;

endpackage : rmd_pkg

/* rmd_alu.sv */
// rmd_alu: registered arithmetic/logic result for a decoded operation
module rmd_alu (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic exec_valid,
  input wire rmd_pkg::rmd_op_t exec_op,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] idx_in,
  input wire logic [7:0] mem_in,
  input wire logic carry_in,
  output logic [7:0] result_q,
  output logic acc_we_q,
  output logic idx_we_q,
  output logic half_carry_q,
  output logic carry_q,
  output logic hc_we_q
);

  function automatic logic [8:0] add9(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic ci);
    add9 = {1'b0, a} + {1'b0, b} + {8'h_00, ci};
  endfunction

  function automatic logic half_of(input logic [7:0] a,
                                   input logic [7:0] b,
                                   input logic ci);
    logic [4:0] s;
    s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h_0, ci};
    half_of = s[rmd_pkg::HC_BIT + 1];
  endfunction

  wire is_adc = (exec_op == rmd_pkg::RMD_OP_ADC);
  wire is_add = (exec_op == rmd_pkg::RMD_OP_ADD);
  wire is_minus_borrow = (exec_op == rmd_pkg::RMD_OP_MINUS_BORROW);
  wire add_ci = is_adc & carry_in;
  wire [8:0] sum9 = add9(acc_in, mem_in, add_ci);
  wire sum_half = half_of(acc_in, mem_in, add_ci);
  // subtract as a + ~b + 1 - borrow
  wire sub_ci = ~(is_minus_borrow & carry_in);
  wire [8:0] dif9 = add9(acc_in, ~mem_in, sub_ci);
  wire [8:0] idx_dif9 = add9(idx_in, ~mem_in, 1'b1);
  logic [7:0] res_d;
  logic acc_we_d;
  logic idx_we_d;
  logic c_d;

  always_comb begin
    res_d = 8'h_00;
    acc_we_d = 1'b0;
    idx_we_d = 1'b0;
    c_d = carry_in;
    unique case (exec_op)
      rmd_pkg::RMD_OP_LOAD_ACC: begin
        res_d = mem_in;
        acc_we_d = 1'b1;
      end
      rmd_pkg::RMD_OP_LOAD_IDX: begin
        res_d = mem_in;
        idx_we_d = 1'b1;
      end
      rmd_pkg::RMD_OP_STORE_ACC: res_d = acc_in;
      rmd_pkg::RMD_OP_STORE_IDX: res_d = idx_in;
      rmd_pkg::RMD_OP_ADD, rmd_pkg::RMD_OP_ADC: begin // [RULE_02]
        res_d = sum9[7:0];
        acc_we_d = 1'b1;
        c_d = sum9[8];
      end
      rmd_pkg::RMD_OP_SUB, rmd_pkg::RMD_OP_MINUS_BORROW: begin // [RULE_03]
        res_d = dif9[7:0];
        acc_we_d = 1'b1;
        c_d = ~dif9[8];
      end
      rmd_pkg::RMD_OP_COMPARE_ACC: begin // [RULE_05]
        res_d = dif9[7:0];
        c_d = ~dif9[8];
      end
      rmd_pkg::RMD_OP_COMPARE_IDX: begin
        res_d = idx_dif9[7:0];
        c_d = ~idx_dif9[8];
      end
      rmd_pkg::RMD_OP_AND: begin
        res_d = acc_in & mem_in;
        acc_we_d = 1'b1;
      end
      rmd_pkg::RMD_OP_BIT_TEST: res_d = acc_in & mem_in; // [RULE_06]
      rmd_pkg::RMD_OP_OR: begin
        res_d = acc_in | mem_in;
        acc_we_d = 1'b1;
      end
      rmd_pkg::RMD_OP_XOR: begin // [RULE_04]
        res_d = acc_in ^ mem_in;
        acc_we_d = 1'b1;
      end
      default: res_d = 8'h_00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= 8'h_00;
      acc_we_q <= 1'b0;
      idx_we_q <= 1'b0;
      half_carry_q <= 1'b0;
      carry_q <= 1'b0;
      hc_we_q <= 1'b0;
    end else begin
      result_q <= res_d;
      acc_we_q <= exec_valid & acc_we_d;
      idx_we_q <= exec_valid & idx_we_d;
      half_carry_q <= sum_half; // [RULE_09]
      carry_q <= c_d;
      hc_we_q <= exec_valid & (is_add | is_adc); // [RULE_09]
    end
  end

endmodule // rmd_alu

/* rmd_fetch_model.sv */
// rmd_fetch_model: fetch sequencer stand-in presenting opcode and operands
module rmd_fetch_model (
  input wire logic sys_clk,
  output logic opcode_valid,
  output logic [7:0] opcode,
  output logic [7:0] acc_in,
  output logic [7:0] idx_in,
  output logic [7:0] mem_in,
  output logic carry_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    opcode_valid = 1'b0;
    opcode = 8'h00;
    acc_in = 8'h00;
    idx_in = 8'h00;
    mem_in = 8'h00;
    carry_in = 1'b0;
  end

  // called at a falling edge; operand fetched from memory arrives with opcode
  task automatic issue(input logic [7:0] op, input logic [7:0] a,
                       input logic [7:0] x, input logic [7:0] m,
                       input logic c);
    opcode_valid = 1'b1;
    opcode = op;
    acc_in = a;
    idx_in = x;
    mem_in = m;
    carry_in = c;
  endtask

  // nothing presented: opcode and mem_in flip so stale values never match
  task automatic idle();
    opcode_valid = 1'b0;
    opcode = ~opcode;
    mem_in = ~mem_in;
  endtask
endmodule // rmd_fetch_model

/* regmem_opcode_decoder_tb_top.sv */
// regmem_opcode_decoder_tb_top: self-checking bench for rmd_decoder
module regmem_opcode_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk;
  logic rst_n;
  logic opcode_valid;
  logic [7:0] opcode, acc_in, idx_in, mem_in;
  logic carry_in;
  logic dec_valid_q, dec_illegal_q, dec_mem_write_q, dec_mem_read_q;
  rmd_pkg::rmd_op_t dec_op_q;
  rmd_pkg::rmd_mode_t dec_mode_q;
  rmd_pkg::rmd_reg_t dec_reg_q;
  logic [1:0] dec_len_q;
  logic [3:0] dec_cycles_q;
  logic [7:0] result_q;
  logic acc_we_q, idx_we_q, half_carry_q, carry_q, hc_we_q;
  int errors = 0;
  int tests_run = 0;

  rmd_fetch_model u_fetch (.sys_clk(sys_clk), .opcode_valid(opcode_valid),
    .opcode(opcode), .acc_in(acc_in), .idx_in(idx_in), .mem_in(mem_in),
    .carry_in(carry_in));

  rmd_decoder u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .opcode_valid(opcode_valid), .opcode(opcode), .acc_in(acc_in),
    .idx_in(idx_in), .mem_in(mem_in), .carry_in(carry_in),
    .dec_valid_q(dec_valid_q), .dec_illegal_q(dec_illegal_q),
    .dec_op_q(dec_op_q), .dec_mode_q(dec_mode_q), .dec_reg_q(dec_reg_q),
    .dec_len_q(dec_len_q), .dec_cycles_q(dec_cycles_q),
    .dec_mem_write_q(dec_mem_write_q), .dec_mem_read_q(dec_mem_read_q),
    .result_q(result_q), .acc_we_q(acc_we_q), .idx_we_q(idx_we_q),
    .half_carry_q(half_carry_q), .carry_q(carry_q), .hc_we_q(hc_we_q));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic rmd_pkg::rmd_op_t exp_op(input logic [3:0] lo);
    rmd_pkg::rmd_op_t t[16];
    t = '{rmd_pkg::RMD_OP_SUB, rmd_pkg::RMD_OP_COMPARE_ACC,
      rmd_pkg::RMD_OP_MINUS_BORROW, rmd_pkg::RMD_OP_COMPARE_IDX,
      rmd_pkg::RMD_OP_AND, rmd_pkg::RMD_OP_BIT_TEST,
      rmd_pkg::RMD_OP_LOAD_ACC, rmd_pkg::RMD_OP_STORE_ACC, rmd_pkg::RMD_OP_XOR,
      rmd_pkg::RMD_OP_ADC, rmd_pkg::RMD_OP_OR, rmd_pkg::RMD_OP_ADD,
      rmd_pkg::RMD_OP_JUMP, rmd_pkg::RMD_OP_CALL, rmd_pkg::RMD_OP_LOAD_IDX,
      rmd_pkg::RMD_OP_STORE_IDX};
    return t[lo];
  endfunction

  // one opcode per cycle; outputs judged one cycle after it is taken
  task automatic sweep();
    logic [3:0] hi, lo;
    logic st, jc, legal;
    logic [3:0] cyc;
    logic [7:0] md;
    logic [7:0] ln;
    logic [7:0] rg;
    for (int h = 10; h < 16; h++) begin
      for (int l = 0; l < 16; l++) begin
        hi = 4'(h);
        lo = 4'(l);
        st = (lo == 4'h7) || (lo == 4'hF);
        jc = (lo == 4'hC) || (lo == 4'hD);
        legal = !(hi == 4'hA && (st || jc));
        case (hi)
          4'hA: begin
            cyc = 4'h2;
            md = 8'(rmd_pkg::RMD_MODE_IMM);
            ln = 8'h02;
          end
          4'hB: begin
            cyc = 4'h3;
            md = 8'(rmd_pkg::RMD_MODE_DIR);
            ln = 8'h02;
          end
          4'hC: begin
            cyc = 4'h4;
            md = 8'(rmd_pkg::RMD_MODE_EXT);
            ln = 8'h03;
          end
          4'hD: begin
            cyc = 4'h5;
            md = 8'(rmd_pkg::RMD_MODE_IX2);
            ln = 8'h03;
          end
          4'hE: begin
            cyc = 4'h4;
            md = 8'(rmd_pkg::RMD_MODE_IX1);
            ln = 8'h02;
          end
          default: begin
            cyc = 4'h3;
            md = 8'(rmd_pkg::RMD_MODE_IX0);
            ln = 8'h01;
          end
        endcase
        cyc = st ? cyc + 4'h1 : (lo == 4'hC) ? cyc - 4'h1 :
          (lo == 4'hD) ? cyc + 4'h2 : cyc;
        rg = jc ? 8'(rmd_pkg::RMD_REG_NONE) :
          (lo == 4'h3 || lo == 4'hE || lo == 4'hF) ?
          8'(rmd_pkg::RMD_REG_IDX) : 8'(rmd_pkg::RMD_REG_ACC);
        u_fetch.issue({hi, lo}, 8'h11, 8'h22, 8'h33, 1'b0);
        @(negedge sys_clk);
        check(8'(dec_valid_q), 8'(legal));
        check(8'(dec_illegal_q), 8'(!legal));
        if (legal) begin
          check(8'(dec_mode_q), md);
          check(8'(dec_len_q), ln);
          check(8'(dec_cycles_q), 8'(cyc));
          check(8'(dec_op_q), 8'(exp_op(lo)));
          check(8'(dec_reg_q), rg);
          check(8'(dec_mem_write_q), 8'(st));
          check(8'(dec_mem_read_q), 8'(hi != 4'hA && !st && !jc));
        end else begin
          check(8'(dec_len_q), 8'h00);
          check(8'(dec_mem_write_q), 8'h00);
          check(8'(dec_op_q), 8'(rmd_pkg::RMD_OP_NONE));
        end
      end
    end
  endtask

  task automatic alu(input logic [7:0] op, input logic [7:0] a,
                     input logic [7:0] x, input logic [7:0] m, input logic c,
                     input logic [7:0] r, input logic aw, input logic iw,
                     input logic ec, input logic hw, input logic hc);
    u_fetch.issue(op, a, x, m, c);
    @(negedge sys_clk);
    check(result_q, r);
    check({6'h00, acc_we_q, idx_we_q}, {6'h00, aw, iw});
    check({7'h00, carry_q}, {7'h00, ec});
    check({7'h00, hc_we_q}, {7'h00, hw});
    if (hw) begin
      check({7'h00, half_carry_q}, {7'h00, hc});
    end
  endtask

  task automatic arith();
    alu(8'hAB, 8'h08, 8'h00, 8'h08, 1'b0, 8'h10,
      1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    alu(8'hA9, 8'h0F, 8'h00, 8'h00, 1'b1, 8'h10,
      1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    alu(8'hD9, 8'hFF, 8'h00, 8'h01, 1'b0, 8'h00,
      1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    alu(8'hA9, 8'h10, 8'h00, 8'h20, 1'b0, 8'h30,
      1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    alu(8'hA2, 8'h10, 8'h00, 8'h01, 1'b1, 8'h0E,
      1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    alu(8'hD2, 8'h00, 8'h00, 8'h00, 1'b1, 8'hFF,
      1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    alu(8'hE8, 8'hF0, 8'h00, 8'h3C, 1'b1, 8'hCC,
      1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    alu(8'hA1, 8'h05, 8'h00, 8'h07, 1'b0, 8'hFE,
      1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    alu(8'hD1, 8'h07, 8'h00, 8'h05, 1'b1, 8'h02,
      1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    alu(8'hB5, 8'hF0, 8'h00, 8'h3C, 1'b0, 8'h30,
      1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    alu(8'hAE, 8'h00, 8'h00, 8'h5A, 1'b0, 8'h5A,
      1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    alu(8'hBF, 8'h00, 8'h77, 8'h00, 1'b0, 8'h77,
      1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    alu(8'hA0, 8'h05, 8'h00, 8'h06, 1'b1, 8'hFF,
      1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    alu(8'hAA, 8'h0F, 8'h00, 8'hF0, 1'b0, 8'hFF,
      1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    alu(8'hA3, 8'h00, 8'h10, 8'h10, 1'b0, 8'h00,
      1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    alu(8'h42, 8'h01, 8'h01, 8'h01, 1'b0, 8'h00,
      1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    check(8'(dec_illegal_q), 8'h01);
    check(8'(dec_valid_q), 8'h00);
  endtask

  // reset in mid-run clears a pending answer at once
  task automatic mid_reset();
    u_fetch.issue(8'hAB, 8'h01, 8'h00, 8'h01, 1'b0);
    @(negedge sys_clk);
    u_fetch.idle();
    rst_n = 1'b0;
    #1;
    check({6'h00, dec_valid_q, acc_we_q}, 8'h00);
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    check({4'h0, dec_cycles_q}, 8'h00);
    check(8'(dec_op_q), 8'(rmd_pkg::RMD_OP_NONE));
  endtask

  initial begin
    #50000;
    errors++;
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    sweep();
    arith();
    mid_reset();
    summarize();
  end
endmodule // regmem_opcode_decoder_tb_top
